//--- rtl/card_power_pkg.sv
// Package: constants, types and decode functions of the card power controller
package card_power_pkg;

    // ------------------------------------------------------------
    // Control word layout
    // ------------------------------------------------------------
    localparam int WORD_BITS = 11;          // Bits in one serial control word
    localparam int POS_A_PROG0 = 0;         // Slot A prog select, first bit
    localparam int POS_A_PROG1 = 1;         // Slot A prog select, second bit
    localparam int POS_A_CORE_LO = 2;       // Slot A core select, low bit
    localparam int POS_A_CORE_HI = 3;       // Slot A core select, high bit
    localparam int POS_B_PROG0 = 4;         // Slot B prog select, first bit
    localparam int POS_B_PROG1 = 5;         // Slot B prog select, second bit
    localparam int POS_B_CORE_HI = 6;       // Slot B core select, high bit
    localparam int POS_B_CORE_LO = 7;       // Slot B core select, low bit
    localparam int POS_SHUTDOWN = 8;        // Shutdown bit, low means shut down
    localparam int POS_A_PROG_X = 9;        // Slot A prog 3.3 V / 5 V pick
    localparam int POS_B_PROG_X = 10;       // Slot B prog 3.3 V / 5 V pick
    localparam logic [10:0] WORD_RESET = 11'h000; // Word after reset

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    localparam int FAULT_INPUTS = 5;        // Four output faults plus overtemp
    localparam logic [2:0] LINK_SYNC_RESET = 3'h0; // Link synchroniser value
    localparam logic [7:0] PIN_SYNC_RESET = 8'h00; // Pins sync, reset_n low

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_WORD = 8'h00;       // Latched word and hold flag
    localparam logic [7:0] REG_STATUS = 8'h04;     // Live status
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08; // Sticky events, write one
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;   // Event enables
    localparam int POS_GROUNDED = 16;       // Hold flag in the word register
    localparam int IRQ_BITS = 3;            // Number of event bits
    localparam int IRQ_WORD_TAKEN = 0;      // A word was latched
    localparam int IRQ_LATCH_REFUSED = 1;   // Latch seen during reset
    localparam int IRQ_OVERCURRENT = 2;     // Fault condition began
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0; // Mask after reset

    // ------------------------------------------------------------
    // Output switch settings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        sup_gnd, sup_3v3, sup_5v, sup_12v, sup_hiz
    } supply_t;

    // Core supply from its two select bits
    function automatic supply_t decode_core(input logic hi, input logic lo,
                                            input logic shut_off_n);
        supply_t res;
        res = sup_gnd;
        if (!shut_off_n) begin
            res = sup_hiz;
        end else if ({hi, lo} == 2'h1) begin
            res = sup_3v3;
        end else if ({hi, lo} == 2'h2) begin
            res = sup_5v;
        end
        return res;
    endfunction : decode_core

    // Programming supply, independent or legacy selection
    function automatic supply_t decode_prog(input logic indep, input logic b0,
                                            input logic b1, input logic bx,
                                            input logic shut_off_n,
                                            input supply_t core);
        supply_t res;
        res = sup_gnd;
        if (!shut_off_n) begin
            res = sup_hiz;
        end else begin
            unique case ({b0, b1})
                2'h0: res = sup_gnd;
                2'h1: res = indep ? (bx ? sup_5v : sup_3v3) : core;
                2'h2: res = sup_12v;
                2'h3: res = sup_hiz;
            endcase
        end
        return res;
    endfunction : decode_prog

endpackage : card_power_pkg

//--- rtl/link_word_if.sv
// Interface: shifted control word and latch event between link sampler and core
interface link_word_if;
    import card_power_pkg::*;
    logic [WORD_BITS-1:0] word;    // Serial shift contents
    logic latch_pulse;             // One cycle on a latch rising edge
    modport source(output word, output latch_pulse);
    modport sink(input word, input latch_pulse);
endinterface : link_word_if

//--- rtl/serial_link_sampler.sv
// Module: samples the three-wire link and shifts the control word
module serial_link_sampler
    import card_power_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Link pins
    input wire logic link_data,
    input wire logic link_clock,
    input wire logic link_latch,
    // Word to the core
    link_word_if.source lw
);

    // ------------------------------------------------------------
    // Synchronisers, bit order {latch, clock, data}
    // ------------------------------------------------------------
    logic [2:0] sync_a;   // First stage, read only by sync_b
    logic [2:0] sync_b;   // Second stage
    logic [2:0] sync_d;   // Delayed copy for edge finding
    wire clock_rise = sync_b[1] & ~sync_d[1];
    wire latch_rise = sync_b[2] & ~sync_d[2];

    // Two flops per pin; all three share one delay so order is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= LINK_SYNC_RESET;
            sync_b <= LINK_SYNC_RESET;
            sync_d <= LINK_SYNC_RESET;
        end else if (clk_en) begin
            sync_a <= {link_latch, link_clock, link_data};
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end

    // ------------------------------------------------------------
    // Shift register and latch event
    // ------------------------------------------------------------
    // Data taken on clock rise, first bit ends up at the top [R7] [R18]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lw.word <= WORD_RESET;
            lw.latch_pulse <= 1'b0;
        end else if (clk_en) begin
            if (clock_rise) begin
                lw.word <= {lw.word[WORD_BITS-2:0], sync_b[0]}; // [R7]
            end
            lw.latch_pulse <= latch_rise; // [R8]
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_shift_data: assert property (@(posedge pclk) disable iff (!presetn || !clk_en) // [R7]
        clock_rise |=> lw.word == {$past(lw.word[9:0]), $past(sync_b[0])})
        else $error("shift register missed a clock edge");
    a_latch_edge: assert property (@(posedge pclk) disable iff (!presetn || !clk_en)
        latch_rise |=> lw.latch_pulse ##1 !lw.latch_pulse) // [R8]
        else $error("latch pulse not one cycle");

endmodule : serial_link_sampler

//--- rtl/card_power_ctrl.sv
// Module: dual-slot card power control logic with serial link and APB registers
//
// Functional notes
// [R1] Mode pin high independent, low/floating legacy
// [R2] Independent prog supply ignores core setting
// [R3] Either reset grounds all four supply outputs
// [R4] Stay grounded until a new word latched
// [R5] Latch edges ignored while reset asserted
// [R6] Power-up enters the same grounded state
// [R7] Data shifted on serial clock rising edge
// [R8] Latch rise copies eleven bits in parallel
// [R9] Host latches before next serial clock edge
// [R10] Flag low on any overcurrent or overtemperature
// [R11] Slot A core from bits 3,2
// [R12] Slot B core from bits 6,7
// [R13] Independent slot A prog from 0,1,9
// [R14] Independent slot B prog from 4,5,10
// [R15] Legacy slot A prog 01 follows core
// [R16] Legacy slot B prog 01 follows core
// [R17] Shutdown bit low makes all outputs high-impedance
// [R18] Word shifted most significant bit first
// [R19] Output register changes only on latch
module card_power_ctrl
    import card_power_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial link pins
    input wire logic link_data,
    input wire logic link_clock,
    input wire logic link_latch,
    // Reset and mode pins
    input wire logic reset_high_pin,
    input wire logic reset_n_pin,
    input wire logic mode_pin,
    // Fault sense: four outputs and overtemperature
    input wire logic [FAULT_INPUTS-1:0] fault_in,
    // Supply switch controls
    output supply_t slot_a_core_supply,
    output supply_t slot_a_prog_supply,
    output supply_t slot_b_core_supply,
    output supply_t slot_b_prog_supply,
    output logic ground_switch_one,
    output logic ground_switch_four,
    output logic ground_switch_seven,
    output logic ground_switch_eleven,
    // Flags
    output logic overcurrent_flag_n,
    output logic irq
);

    // ------------------------------------------------------------
    // Link sampler
    // ------------------------------------------------------------
    link_word_if lw ();

    serial_link_sampler u_link (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .link_data(link_data),
        .link_clock(link_clock),
        .link_latch(link_latch),
        .lw(lw)
    );

    // ------------------------------------------------------------
    // Pin synchronisers {faults, mode, reset_n, reset_high}
    // ------------------------------------------------------------
    logic [7:0] pin_a;   // First stage, read only by pin_b
    logic [7:0] pin_b;   // Second stage

    // Two flops per pin; reset_n stage resets low so reset holds at power-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a <= PIN_SYNC_RESET;
            pin_b <= PIN_SYNC_RESET;
        end else if (clk_en) begin
            pin_a <= {fault_in, mode_pin, reset_n_pin, reset_high_pin};
            pin_b <= pin_a;
        end
    end

    wire reset_req = pin_b[0] | ~pin_b[1];       // Either reset pin active [R3]
    wire mode_indep = pin_b[2];                  // High means independent [R1]
    wire [FAULT_INPUTS-1:0] fault_s = pin_b[7:3]; // Synced fault lines
    wire fault_any = |fault_s;                   // Any fault [R10]

    // ------------------------------------------------------------
    // Output control register
    // ------------------------------------------------------------
    logic [WORD_BITS-1:0] latched_word; // Word driving the switches
    logic grounded;                     // Hold outputs grounded
    logic fault_d;                      // Last fault state for edge

    wire take_word = lw.latch_pulse & ~reset_req;   // Latch accepted [R5]
    wire refuse_word = lw.latch_pulse & reset_req;  // Latch dropped [R5]

    // Word updates only on an accepted latch; reset clears and holds [R19]
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_word <= WORD_RESET;
            grounded <= 1'b1;                        // [R6]
        end else if (clk_en) begin
            if (reset_req) begin
                latched_word <= WORD_RESET;          // [R5]
                grounded <= 1'b1;                    // [R3]
            end else if (take_word) begin
                latched_word <= lw.word;             // [R8] [R19]
                grounded <= 1'b0;                    // [R4]
            end
        end
    end

    // ------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------
    wire shut_off_n = latched_word[POS_SHUTDOWN];   // Low means shut down [R17]
    // Core selections, same in both modes [R11] [R12]
    wire supply_t dec_a_core = decode_core(latched_word[POS_A_CORE_HI],
        latched_word[POS_A_CORE_LO], shut_off_n);
    wire supply_t dec_b_core = decode_core(latched_word[POS_B_CORE_HI],
        latched_word[POS_B_CORE_LO], shut_off_n);
    // Prog selections, mode picks the table [R1] [R2] [R13] [R14] [R15] [R16]
    wire supply_t dec_a_prog = decode_prog(mode_indep, latched_word[POS_A_PROG0],
        latched_word[POS_A_PROG1], latched_word[POS_A_PROG_X], shut_off_n, dec_a_core);
    wire supply_t dec_b_prog = decode_prog(mode_indep, latched_word[POS_B_PROG0],
        latched_word[POS_B_PROG1], latched_word[POS_B_PROG_X], shut_off_n, dec_b_core);
    // Grounded hold wins over any decoded value [R3] [R4]
    wire supply_t next_a_core = grounded ? sup_gnd : dec_a_core;
    wire supply_t next_a_prog = grounded ? sup_gnd : dec_a_prog;
    wire supply_t next_b_core = grounded ? sup_gnd : dec_b_core;
    wire supply_t next_b_prog = grounded ? sup_gnd : dec_b_prog;

    // Switch control flops; ground switch closes with a grounded output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_a_core_supply <= sup_gnd;
            slot_a_prog_supply <= sup_gnd;
            slot_b_core_supply <= sup_gnd;
            slot_b_prog_supply <= sup_gnd;
            ground_switch_one <= 1'b1;
            ground_switch_four <= 1'b1;
            ground_switch_seven <= 1'b1;
            ground_switch_eleven <= 1'b1;
        end else if (clk_en) begin
            slot_a_core_supply <= next_a_core;
            slot_a_prog_supply <= next_a_prog;
            slot_b_core_supply <= next_b_core;
            slot_b_prog_supply <= next_b_prog;
            ground_switch_one <= (next_a_core == sup_gnd);    // [R3]
            ground_switch_four <= (next_a_prog == sup_gnd);   // [R3]
            ground_switch_seven <= (next_b_core == sup_gnd);  // [R3]
            ground_switch_eleven <= (next_b_prog == sup_gnd); // [R3]
        end
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic [IRQ_BITS-1:0] irq_status; // Sticky events
    logic [IRQ_BITS-1:0] irq_mask;   // Event enables

    wire apb_done = psel & penable & pready;        // Access edge
    wire apb_wr = apb_done & pwrite;                 // Write takes effect
    wire sel_word = (paddr == REG_WORD);
    wire sel_stat = (paddr == REG_STATUS);
    wire sel_istat = (paddr == REG_IRQ_STATUS);
    wire sel_imask = (paddr == REG_IRQ_MASK);
    wire mapped = sel_word | sel_stat | sel_istat | sel_imask;
    wire [31:0] word_view = {15'h0000, grounded, 5'h00, latched_word};
    wire [31:0] stat_view = {29'h00000000, reset_req, fault_any, mode_indep};
    wire [31:0] rd_mux = sel_word ? word_view :
                         sel_stat ? stat_view :
                         sel_istat ? {29'h00000000, irq_status} :
                         sel_imask ? {29'h00000000, irq_mask} : 32'h00000000;

    // No wait state: answer registered during the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready <= psel & ~penable;
            prdata <= (psel & ~penable) ? rd_mux : 32'h00000000;
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    wire [IRQ_BITS-1:0] events = {fault_any & ~fault_d, refuse_word, take_word};
    wire [IRQ_BITS-1:0] clr = (apb_wr & sel_istat) ? pwdata[IRQ_BITS-1:0] : 3'h0;
    // Set wins over a clear in the same cycle
    wire [IRQ_BITS-1:0] next_irq_status = (irq_status & ~clr) | events;
    wire [IRQ_BITS-1:0] next_irq_mask = (apb_wr & sel_imask) ?
                                        pwdata[IRQ_BITS-1:0] : irq_mask;

    // Status, mask, fault edge and the two flag outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= 3'h0;
            irq_mask <= IRQ_MASK_RESET;
            fault_d <= 1'b0;
            irq <= 1'b0;
            overcurrent_flag_n <= 1'b1;
        end else if (clk_en) begin
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            fault_d <= fault_any;
            irq <= |(next_irq_status & next_irq_mask);
            overcurrent_flag_n <= ~fault_any;        // [R10]
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn || !clk_en);

    a_reset_grounds: assert property (reset_req |-> ##2 // [R3]
        (slot_a_core_supply == sup_gnd && slot_b_prog_supply == sup_gnd &&
         ground_switch_one && ground_switch_eleven))
        else $error("reset did not ground the outputs");
    a_ground_release: assert property ($fell(grounded) |-> $past(take_word)) // [R4]
        else $error("grounded hold released without a latch");
    a_latch_blocked: assert property (refuse_word |=> latched_word == 11'h000) // [R5]
        else $error("latch taken during reset");
    a_grounded_out: assert property (grounded |=> // [R6]
        slot_b_core_supply == sup_gnd && slot_a_prog_supply == sup_gnd)
        else $error("output live while held grounded");
    a_latch_copy: assert property (take_word |=> latched_word == $past(lw.word)) // [R8]
        else $error("latched word differs from shift contents");
    a_word_hold: assert property (!lw.latch_pulse && !reset_req |=> $stable(latched_word)) // [R19]
        else $error("output register moved without a latch");
    a_fault_flag: assert property (fault_any |=> !overcurrent_flag_n) // [R10]
        else $error("fault flag not raised");
    a_core_decode: assert property (!grounded && shut_off_n && // [R12]
        latched_word[POS_B_CORE_HI] && !latched_word[POS_B_CORE_LO]
        |=> slot_b_core_supply == sup_5v)
        else $error("slot B core decode wrong");
    a_indep_prog: assert property (!grounded && mode_indep && shut_off_n && // [R13]
        latched_word[1:0] == 2'h2 && latched_word[POS_A_PROG_X]
        |=> slot_a_prog_supply == sup_5v)
        else $error("independent prog decode wrong");
    a_legacy_follow: assert property (!grounded && !mode_indep && shut_off_n && // [R16]
        latched_word[5:4] == 2'h2 |=> slot_b_prog_supply == slot_b_core_supply)
        else $error("legacy prog not following core");
    a_shutdown_hiz: assert property (!grounded && !shut_off_n |=> // [R17]
        slot_a_core_supply == sup_hiz && slot_b_prog_supply == sup_hiz)
        else $error("shutdown not high impedance");
    a_irq_level: assert property (irq == |(irq_status & irq_mask))
        else $error("interrupt level disagrees with status");

    c_indep_word: cover property (take_word && mode_indep ##1 !grounded);
    c_legacy_word: cover property (take_word && !mode_indep ##1 !grounded);
    c_shutdown: cover property (!grounded && !shut_off_n);
    c_refused: cover property (refuse_word);

endmodule : card_power_ctrl

//--- tb/link_host_model.sv
// Serial host model of the three-wire link
module link_host_model (
    // Link pins
    output logic link_data,
    output logic link_clock,
    output logic link_latch
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------
    initial begin // Idle low
        link_data = 1'b0;
        link_clock = 1'b0;
        link_latch = 1'b0;
    end
    // One word, 800 ns link clock, latch optional
    task automatic send_word(input logic [10:0] w, bit do_latch);
        #37; // Off the block clock phase
        for (int i = 10; i >= 0; i--) begin
            link_data = w[i]; // Set while clock low
            #400 link_clock = 1'b1;
            #400 link_clock = 1'b0;
        end
        if (do_latch) begin
            link_latch = 1'b1;
            #400 link_latch = 1'b0;
        end
        link_data = ~link_data; // No stale bit
    endtask : send_word
endmodule : link_host_model

//--- tb/test_card_power_ctrl.sv
// Self-checking bench of the card power controller
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_card_power_ctrl
    import card_power_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err, irq, flag_n;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic link_data, link_clock, link_latch, reset_high_pin, reset_n_pin, mode_pin;
    logic [FAULT_INPUTS-1:0] fault_in;
    supply_t core_a, prog_a, core_b, prog_b;
    logic gs1, gs4, gs7, gs11;
    int n_fail = 0, checks = 0, cycles = 0;
    card_power_ctrl u_card_power_ctrl (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .link_data, .link_clock, .link_latch,
        .reset_high_pin, .reset_n_pin, .mode_pin, .fault_in, .slot_a_core_supply(core_a),
        .slot_a_prog_supply(prog_a), .slot_b_core_supply(core_b), .slot_b_prog_supply(prog_b),
        .ground_switch_one(gs1), .ground_switch_four(gs4), .ground_switch_seven(gs7),
        .ground_switch_eleven(gs11), .overcurrent_flag_n(flag_n), .irq);
    link_host_model u_link_host_model (.link_data, .link_clock, .link_latch);
    always #50 pclk = ~pclk; // 10 MHz block clock
    always @(posedge pclk) begin // Hang guard
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic stop_test(); // Counts, verdict, end of run
        $display("Checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test
    task automatic tick(input int n); // Let n clock edges pass
        repeat (n) @(posedge pclk);
    endtask : tick
    task automatic apb(input logic wr, logic [7:0] a, logic [31:0] wd);
        @(posedge pclk); // Setup phase
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk); // Access phase until pready
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic supply_t core_exp(logic [1:0] c); // Core table
        return (c == 2'h1) ? sup_3v3 : (c == 2'h2) ? sup_5v : sup_gnd;
    endfunction : core_exp
    function automatic supply_t prog_exp(logic ind, logic [2:0] p, supply_t c);
        return (p[2:1] == 2'h0) ? sup_gnd : (p[2:1] == 2'h2) ? sup_12v :
            (p[2:1] == 2'h3) ? sup_hiz : !ind ? c : p[0] ? sup_5v : sup_3v3;
    endfunction : prog_exp
    // Word from core codes, prog codes {b0,b1,x} and shutdown bit
    function automatic logic [10:0] mk(logic [1:0] ac, logic [1:0] bc, logic [2:0] ap,
        logic [2:0] bp, logic on);
        return {bp[0], ap[0], on, bc[0], bc[1], bp[1], bp[2], ac[1], ac[0], ap[1], ap[2]};
    endfunction : mk
    task automatic word(input logic [10:0] w); // Latched word, then settle
        u_link_host_model.send_word(w, 1'b1);
        tick(6);
    endtask : word
    task automatic chk4(supply_t ea, supply_t pa, supply_t eb, supply_t pb);
        logic [3:0] g;
        g = {ea == sup_gnd, pa == sup_gnd, eb == sup_gnd, pb == sup_gnd};
        `CHK("a core", ea, core_a)
        `CHK("a prog", pa, prog_a)
        `CHK("b core", eb, core_b)
        `CHK("b prog", pb, prog_b)
        `CHK("gnd sw", g, {gs1, gs4, gs7, gs11})
    endtask : chk4
    task automatic chk_all(supply_t s); // Same value on all four outputs
        chk4(s, s, s, s);
    endtask : chk_all
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_power_up(); // Grounded state, mask reset, unmapped access
        chk_all(sup_gnd);
        `CHK("flag", 1'b1, flag_n)
        apb(1'b0, REG_IRQ_MASK, 32'h0);
        `CHK("mask", 32'h0, rd)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("slverr", 1'b1, err)
        $display("Done power up");
    endtask : t_power_up
    task automatic t_core(); // Every core code on both slots
        logic [1:0] c;
        mode_pin <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            word(mk(c, ~c, 3'h0, 3'h0, 1'b1));
            chk4(core_exp(c), sup_gnd, core_exp(~c), sup_gnd);
        end
        $display("Done core");
    endtask : t_core
    task automatic t_prog(); // Every prog code, independent then legacy
        logic [2:0] p;
        for (int i = 0; i < 8; i++) begin
            p = i[2:0];
            mode_pin <= 1'b1;
            word(mk(2'h2, 2'h1, p, ~p, 1'b1));
            chk4(sup_5v, prog_exp(1'b1, p, sup_5v), sup_3v3, prog_exp(1'b1, ~p, sup_3v3));
            mode_pin <= 1'b0;
            tick(6);
            chk4(sup_5v, prog_exp(1'b0, p, sup_5v), sup_3v3, prog_exp(1'b0, ~p, sup_3v3));
        end
        $display("Done prog");
    endtask : t_prog
    task automatic t_shut(); // Shutdown, then shifted bits without latch
        word(mk(2'h1, 2'h2, 3'h2, 3'h4, 1'b0));
        chk_all(sup_hiz);
        u_link_host_model.send_word(mk(2'h2, 2'h2, 3'h0, 3'h0, 1'b1), 1'b0);
        tick(6);
        chk_all(sup_hiz);
        $display("Done shutdown");
    endtask : t_shut
    task automatic t_resets(); // Both reset pins, refused latch, hold
        word(mk(2'h1, 2'h1, 3'h2, 3'h2, 1'b1));
        reset_high_pin <= 1'b1;
        apb(1'b1, REG_IRQ_STATUS, 32'h7);
        tick(4);
        chk_all(sup_gnd);
        word(mk(2'h2, 2'h2, 3'h2, 3'h2, 1'b1));
        chk_all(sup_gnd);
        reset_high_pin <= 1'b0;
        tick(6);
        chk_all(sup_gnd);
        apb(1'b0, REG_IRQ_STATUS, 32'h0);
        `CHK("refused", 1'b1, rd[IRQ_LATCH_REFUSED])
        word(mk(2'h2, 2'h1, 3'h6, 3'h0, 1'b1));
        chk4(sup_5v, sup_hiz, sup_3v3, sup_gnd);
        reset_n_pin <= 1'b0;
        tick(6);
        chk_all(sup_gnd);
        reset_n_pin <= 1'b1;
        tick(6);
        $display("Done resets");
    endtask : t_resets
    task automatic t_irq(); // Events, mask, write-one clear, faults
        apb(1'b1, REG_IRQ_STATUS, 32'h7);
        apb(1'b1, REG_IRQ_MASK, 32'h7);
        tick(3);
        `CHK("irq clear", 1'b0, irq)
        word(mk(2'h1, 2'h1, 3'h0, 3'h0, 1'b1));
        `CHK("irq word", 1'b1, irq)
        apb(1'b1, REG_IRQ_STATUS, 32'h1);
        tick(3);
        `CHK("irq w1c", 1'b0, irq)
        for (int i = 0; i < FAULT_INPUTS; i++) begin
            fault_in <= 5'h01 << i;
            tick(5);
            `CHK("flag low", 1'b0, flag_n)
            fault_in <= 5'h00;
            tick(5);
            `CHK("flag high", 1'b1, flag_n)
        end
        `CHK("irq fault", 1'b1, irq)
        apb(1'b1, REG_IRQ_MASK, 32'h0);
        tick(3);
        `CHK("irq masked", 1'b0, irq)
        $display("Done irq");
    endtask : t_irq
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {reset_high_pin, mode_pin, fault_in} = '0;
        {clk_en, reset_n_pin} = 2'h3;
        tick(6);
        presetn <= 1'b1;
        tick(6);
        t_power_up();
        t_core();
        t_prog();
        t_shut();
        t_resets();
        t_irq();
        stop_test();
    end
endmodule : test_card_power_ctrl
